// ### core/host_port_pkg.sv
// Constants, timing and states for the timekeeping SRAM host controller
package host_port_pkg;

  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam int CNT_W  = 8;
  localparam int SYNC_W = DATA_W + 3;

  // Clock-register window: top sixteen byte locations
  localparam logic [ADDR_W-1:0] CLOCK_BASE_ADDR = 19'h7FFF0;
  localparam logic [ADDR_W-1:0] FLAGS_ADDR      = 19'h7FFF0;
  localparam logic [ADDR_W-1:0] INTR_CFG_ADDR   = 19'h7FFF6;
  localparam logic [ADDR_W-1:0] WATCHDOG_ADDR   = 19'h7FFF7;
  localparam logic [ADDR_W-1:0] CONTROL_ADDR    = 19'h7FFF8;
  localparam logic [ADDR_W-1:0] SECONDS_ADDR    = 19'h7FFF9;
  localparam logic [ADDR_W-1:0] YEAR_ADDR       = 19'h7FFFF;
  localparam int CONTROL_WRITE_HALT_BIT = 7;
  localparam int CONTROL_READ_HALT_BIT  = 6;
  localparam int OSC_STOP_BIT           = 7;

  // Pin timing in ns
  localparam int CLK_PERIOD_NS           = 4;
  localparam int ADDRESS_ACCESS_TIME_NS  = 70;
  localparam int SELECT_ACCESS_TIME_NS   = 70;
  localparam int OUTPUT_ACCESS_TIME_NS   = 35;
  localparam int ADDRESS_SETUP_NS        = 4;
  localparam int WRITE_PULSE_NS          = 55;
  localparam int DATA_HOLD_NS            = 5;
  localparam int WRITE_RECOVERY_TIME_NS  = 5;

  localparam int ACCESS_MAX_NS =
    (ADDRESS_ACCESS_TIME_NS > SELECT_ACCESS_TIME_NS) ?
    ((ADDRESS_ACCESS_TIME_NS > OUTPUT_ACCESS_TIME_NS) ?
      ADDRESS_ACCESS_TIME_NS : OUTPUT_ACCESS_TIME_NS) :
    ((SELECT_ACCESS_TIME_NS > OUTPUT_ACCESS_TIME_NS) ?
      SELECT_ACCESS_TIME_NS : OUTPUT_ACCESS_TIME_NS);

  // Least times round up to whole cycles
  localparam logic [CNT_W-1:0] READ_CYC =
    CNT_W'((ACCESS_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] SETUP_CYC =
    CNT_W'((ADDRESS_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] PULSE_CYC =
    CNT_W'((WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] HOLD_CYC =
    CNT_W'((DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RECOVERY_CYC =
    CNT_W'((WRITE_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] SYNC_CYC = 8'h02;
  localparam logic [CNT_W-1:0] ONE_CYC  = 8'h01;

  typedef enum logic [2:0] {
    IDLE        = 3'b000,
    READ_ACCESS = 3'b001,
    READ_SYNC   = 3'b010,
    WRITE_SETUP = 3'b011,
    WRITE_PULSE = 3'b100,
    WRITE_HOLD  = 3'b101,
    RECOVER     = 3'b110
  } state_e;

endpackage

// ### core/phase_timer_if.sv
// Load and expiry handshake between the sequencer and its phase timer
`timescale 1ns/10ps
interface phase_timer_if
  import host_port_pkg::*;
();
  logic             load;
  logic [CNT_W-1:0] value;
  logic             expired;

  modport owner (output load, output value, input expired);
  modport timer (input load, input value, output expired);
endinterface

// ### core/phase_timer.sv
// Down-counter that times each bus phase in system clock cycles
`timescale 1ns/10ps
module phase_timer
  import host_port_pkg::*;
(
  input  wire logic    clk,    // System clock
  input  wire logic    rst_n,  // Synchronised reset, active low
  phase_timer_if.timer tmr     // Load value, expiry flag
);

  logic [CNT_W-1:0] count;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (tmr.load) begin
      count <= tmr.value;
    end else if (count != '0) begin
      count <= count - CNT_W'(1);
    end
  end

  assign tmr.expired = (count == '0);

endmodule // phase_timer

// ### core/sram_rtc_host.sv
// Host controller driving a timekeeping SRAM over its asynchronous pins
`timescale 1ns/10ps
// Operation
// - Host keeps the address stable for the whole write.
// - Host idles select and write enable for write recovery time.
// - Host drives write data before write end, holds it afterwards.
// - Host should keep output enable inactive during writes.
module sram_rtc_host
  import host_port_pkg::*;
(
  input  wire logic              sys_clk,          // System clock
  input  wire logic              rstn,             // Async reset, low
  input  wire logic              req,              // Access request
  input  wire logic              req_write,        // 1 write, 0 read
  input  wire logic [ADDR_W-1:0] req_addr,         // Byte address
  input  wire logic [DATA_W-1:0] req_wdata,        // Write byte
  output logic                   ready,            // Request taken now
  output logic                   done,             // Access finished
  output logic                   fail,             // Aborted by power or reset
  output logic [DATA_W-1:0]      rd_data,          // Read byte
  output logic                   clock_reg_access, // Last in clock window
  output logic                   alarm_pending,    // Interrupt pin low
  output logic                   device_held,      // Reset pin low
  input  wire logic              power_fail_level, // Supply out of range
  input  wire logic              alarm_irq_n,      // Device interrupt pin
  input  wire logic              dev_rst_n,        // Device reset pin
  output logic                   ce_n,             // Chip select, low
  output logic                   oe_n,             // Output enable, low
  output logic                   we_n,             // Write enable, low
  output logic [ADDR_W-1:0]      addr,             // Address pins
  input  wire logic [DATA_W-1:0] dq_in,            // Data pins, read
  output logic [DATA_W-1:0]      dq_out,           // Data pins, drive
  output logic                   dq_oe             // Data pins enable
);

  logic              rst_meta;
  logic              rst_n;
  logic [SYNC_W-1:0] pin_meta;
  logic [SYNC_W-1:0] pin_sync;
  logic [DATA_W-1:0] dq_sync;
  logic              pf_sync;
  logic              dev_rst_sync;
  logic              alarm_sync;
  logic              link_ok;
  state_e            state;
  state_e            next_state;
  logic              next_done;
  logic              next_fail;

  phase_timer_if tmr ();

  phase_timer u_phase_timer (
    .clk   (sys_clk),
    .rst_n (rst_n),
    .tmr   (tmr.timer)
  );

  // Reset release through two flip-flops
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // All device pins are asynchronous to sys_clk
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {power_fail_level, dev_rst_n, alarm_irq_n, dq_in};
      pin_sync <= pin_meta;
    end
  end

  assign dq_sync      = pin_sync[DATA_W-1:0];
  assign alarm_sync   = pin_sync[DATA_W];
  assign dev_rst_sync = pin_sync[DATA_W+1];
  assign pf_sync      = pin_sync[DATA_W+2];

  // No access while the device is in reset or its supply has failed
  assign link_ok = dev_rst_sync && !pf_sync;

  assign ready = (state == IDLE) && link_ok;

  always_comb begin
    next_state = state;
    next_done  = 1'b0;
    next_fail  = 1'b0;
    tmr.load   = 1'b0;
    tmr.value  = '0;
    case (state)
      IDLE: begin
        if (req && link_ok) begin
          tmr.load = 1'b1;
          if (req_write) begin
            next_state = WRITE_SETUP;
            tmr.value  = SETUP_CYC - ONE_CYC;
          end else begin
            next_state = READ_ACCESS;
            tmr.value  = READ_CYC - ONE_CYC;
          end
        end
      end
      READ_ACCESS: begin
        if (tmr.expired) begin
          next_state = READ_SYNC;
          tmr.load   = 1'b1;
          tmr.value  = SYNC_CYC - ONE_CYC;
        end
      end
      READ_SYNC: begin
        if (tmr.expired) begin
          next_state = RECOVER;
          next_done  = link_ok;
          next_fail  = !link_ok;
          tmr.load   = 1'b1;
          tmr.value  = RECOVERY_CYC - ONE_CYC;
        end
      end
      WRITE_SETUP: begin
        if (tmr.expired) begin
          next_state = WRITE_PULSE;
          tmr.load   = 1'b1;
          tmr.value  = PULSE_CYC - ONE_CYC;
        end
      end
      WRITE_PULSE: begin
        if (tmr.expired) begin
          next_state = WRITE_HOLD;
          tmr.load   = 1'b1;
          tmr.value  = HOLD_CYC - ONE_CYC;
        end
      end
      WRITE_HOLD: begin
        if (tmr.expired) begin
          next_state = RECOVER;
          next_done  = 1'b1;
          tmr.load   = 1'b1;
          tmr.value  = RECOVERY_CYC - ONE_CYC;
        end
      end
      RECOVER: begin
        if (tmr.expired) begin
          next_state = IDLE;
        end
      end
      default: begin
        next_state = IDLE;
      end
    endcase
    // Supply loss ends any cycle at once; a partial write is flagged
    if (!link_ok && state != IDLE && state != RECOVER &&
        next_state != RECOVER) begin
      next_state = RECOVER;
      next_fail  = 1'b1;
      next_done  = 1'b0;
      tmr.load   = 1'b1;
      tmr.value  = RECOVERY_CYC - ONE_CYC;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Strobes registered from the next state so pins never glitch
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ce_n  <= 1'b1;
      oe_n  <= 1'b1;
      we_n  <= 1'b1;
      dq_oe <= 1'b0;
    end else begin
      ce_n  <= !(next_state == READ_ACCESS || next_state == READ_SYNC ||
                 next_state == WRITE_SETUP || next_state == WRITE_PULSE);
      oe_n  <= !(next_state == READ_ACCESS ||
                 next_state == READ_SYNC);
      we_n  <= !(next_state == WRITE_PULSE);
      dq_oe <= (next_state == WRITE_SETUP || next_state == WRITE_PULSE ||
                next_state == WRITE_HOLD);
    end
  end

  // Address and write data latched once and held through the cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr             <= '0;
      dq_out           <= '0;
      clock_reg_access <= 1'b0;
    end else if (state == IDLE && req && link_ok) begin
      addr             <= req_addr;
      dq_out           <= req_wdata;
      clock_reg_access <= (req_addr >= CLOCK_BASE_ADDR);
    end
  end

  // Byte sampled after access time plus synchroniser delay
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else if (state == READ_SYNC && tmr.expired && link_ok) begin
      rd_data <= dq_sync;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      done <= 1'b0;
      fail <= 1'b0;
    end else begin
      done <= next_done;
      fail <= next_fail;
    end
  end

  // Pin levels shown to the user as synchronised flags
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_pending <= 1'b0;
      device_held   <= 1'b1;
    end else begin
      alarm_pending <= !alarm_sync;
      device_held   <= !dev_rst_sync;
    end
  end

endmodule // sram_rtc_host

// ### tb/host_port_checker.sv
// Pin protocol checker for the SRAM host controller
`timescale 1ns/10ps
module host_port_checker
  import host_port_pkg::*;
(
  input wire logic              sys_clk,   // Clock
  input wire logic              rstn,      // Reset
  input wire logic              req,       // Request
  input wire logic              req_write, // Write
  input wire logic              ready,     // Taken
  input wire logic              done,      // Finished
  input wire logic              fail,      // Aborted
  input wire logic              ce_n,      // Select
  input wire logic              oe_n,      // Output en
  input wire logic              we_n,      // Write en
  input wire logic [ADDR_W-1:0] addr,      // Address
  input wire logic [DATA_W-1:0] dq_out,    // Data
  input wire logic              dq_oe      // Drive
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  property p_we_ce; !we_n |-> !ce_n; endproperty
  a_we_ce: assert property (p_we_ce)
    else $error("write strobe outside select");
  property p_oe_wr; !we_n |-> oe_n; endproperty
  a_oe_wr: assert property (p_oe_wr)
    else $error("output enable in write");
  property p_addr; !ce_n && !$past(ce_n) |-> $stable(addr); endproperty
  a_addr: assert property (p_addr)
    else $error("address moved while selected");
  property p_recov; $rose(ce_n) |-> ce_n [*2]; endproperty
  a_recov: assert property (p_recov)
    else $error("recovery too short");
  property p_setup; $fell(we_n) |-> dq_oe && $stable(dq_out); endproperty
  a_setup: assert property (p_setup)
    else $error("data late for write");
  property p_hold;
    $rose(we_n) && dq_oe |-> (dq_oe && $stable(dq_out)) [*2];
  endproperty
  a_hold: assert property (p_hold)
    else $error("data hold too short");
  property p_rd; req && ready && !req_write |-> ##[1:21] (done || fail);
  endproperty
  a_rd: assert property (p_rd)
    else $error("read did not finish");
  property p_wr; req && ready && req_write |-> ##[1:18] (done || fail);
  endproperty
  a_wr: assert property (p_wr)
    else $error("write did not finish");
  property p_gap; done |-> !ready [*2]; endproperty
  a_gap: assert property (p_gap)
    else $error("next access too soon");
  c_rd: cover property (req && ready && !req_write);
  c_wr: cover property (req && ready && req_write);
  c_fail: cover property (fail);
endmodule // host_port_checker

bind sram_rtc_host host_port_checker host_port_checker_i (
  .sys_clk(sys_clk), .rstn(rstn), .req(req), .req_write(req_write),
  .ready(ready), .done(done), .fail(fail), .ce_n(ce_n), .oe_n(oe_n),
  .we_n(we_n), .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe));

// ### tb/sram_dev_model.sv
// Behavioural timekeeping SRAM seen from its pins
`timescale 1ns/10ps
module sram_dev_model
  import host_port_pkg::*;
#(
  parameter int TICK_NS = 2000 // Scaled second of the model
)
(
  input wire logic              ce_n,             // Select
  input wire logic              oe_n,             // Output en
  input wire logic              we_n,             // Write en
  input wire logic [ADDR_W-1:0] addr,             // Address
  input wire logic [DATA_W-1:0] dq,               // Bus level
  input wire logic              power_fail_level, // Blocked
  output logic     [DATA_W-1:0] dq_drv,           // Drive value
  output logic                  dq_en             // Driving
);
  localparam int TICK_STEPS   = 100;
  localparam int TICK_STEP_NS = TICK_NS / TICK_STEPS;
  // Clock window is plain storage apart from the seconds count
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic              wr_act  = 1'b0;
  int                stamp   = 0;
  int                phase   = 0;
  logic [DATA_W-2:0] int_sec = '0;
  logic              int_osc = 1'b0;
  wire               sel = !ce_n && !power_fail_level;
  // Only seconds are counted; minutes and above stay plain storage
  function automatic logic [DATA_W-2:0] sec_inc(
    input logic [DATA_W-2:0] s);
    if (s == 7'h59) return '0;
    if (s[3:0] == 4'h9) return {s[6:4] + 3'h1, 4'h0};
    return s + 7'h01;
  endfunction
  initial begin
    dq_drv = 8'h00;
    mem[CONTROL_ADDR] = 8'h00;
    mem[SECONDS_ADDR] = 8'h00;
  end
  // Internal set counts on while the user set is frozen
  always #(TICK_STEP_NS) begin
    phase++;
    if (phase >= TICK_STEPS) begin
      phase = 0;
      if (!int_osc) int_sec = sec_inc(int_sec);
      if (!mem[CONTROL_ADDR][CONTROL_WRITE_HALT_BIT] &&
          !mem[CONTROL_ADDR][CONTROL_READ_HALT_BIT])
        mem[SECONDS_ADDR] = {int_osc, int_sec};
    end
  end
  always @(addr or ce_n or oe_n or we_n or power_fail_level) begin
    stamp++;
    dq_en = sel && !oe_n && we_n;
    dq_drv = ~dq_drv;
    fork
      begin
        automatic int s = stamp;
        #(ACCESS_MAX_NS);
        if (s == stamp && dq_en) dq_drv = mem[addr];
      end
    join_none
  end
  // Byte lands when the first strobe rises; power loss discards it
  always @(ce_n or we_n or power_fail_level) begin
    if (wr_act && !power_fail_level && (ce_n || we_n)) begin
      // Clearing write-halt loads the user's values into the count
      if (addr == CONTROL_ADDR && !dq[CONTROL_WRITE_HALT_BIT] &&
          mem[CONTROL_ADDR][CONTROL_WRITE_HALT_BIT]) begin
        int_sec = mem[SECONDS_ADDR][DATA_W-2:0];
        int_osc = mem[SECONDS_ADDR][OSC_STOP_BIT];
        phase   = 0;
      end
      mem[addr] = dq;
    end
    wr_act = sel && !we_n;
  end
endmodule // sram_dev_model

// ### tb/testbench.sv
// Self-checking bench for the SRAM host controller
`timescale 1ns/10ps
module testbench
  import host_port_pkg::*;
;
  logic              sys_clk, rstn, req, req_write, power_fail_level;
  logic              alarm_irq_n, dev_rst_n, ready, done, fail, dq_oe;
  logic              clock_reg_access, alarm_pending, device_held;
  logic              ce_n, oe_n, we_n, dev_en;
  logic [ADDR_W-1:0] req_addr, addr;
  logic [DATA_W-1:0] req_wdata, rd_data, dq_out, dev_drv, junk, dq;
  int                error_cnt = 0;
  int                samples_checked = 0;
  int                n;
  localparam int     TICK_NS  = 2000;
  localparam int     TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  logic [ADDR_W-1:0] ta [4] = '{19'h00000, 19'h7FFEF, CONTROL_ADDR,
                                YEAR_ADDR};
  logic [DATA_W-1:0] td [4] = '{8'h3C, 8'hA5, 8'h80, 8'h99};
  // Undriven bus has no pull: it shows the inverse of its last byte
  assign dq = dq_oe ? dq_out : dev_en ? dev_drv : junk;
  always @(dq_oe or dev_en or dq_out or dev_drv) begin
    if (dq_oe) junk = ~dq_out;
    else if (dev_en) junk = ~dev_drv;
  end
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  sram_rtc_host sram_rtc_host_i (
    .sys_clk(sys_clk), .rstn(rstn), .req(req), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .ready(ready),
    .done(done), .fail(fail), .rd_data(rd_data),
    .clock_reg_access(clock_reg_access), .alarm_pending(alarm_pending),
    .device_held(device_held), .power_fail_level(power_fail_level),
    .alarm_irq_n(alarm_irq_n), .dev_rst_n(dev_rst_n), .ce_n(ce_n),
    .oe_n(oe_n), .we_n(we_n), .addr(addr), .dq_in(dq), .dq_out(dq_out),
    .dq_oe(dq_oe));
  sram_dev_model #(.TICK_NS(TICK_NS)) sram_dev_model_i (
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .addr(addr), .dq(dq), .power_fail_level(power_fail_level),
    .dq_drv(dev_drv), .dq_en(dev_en));
  task automatic wrap_up;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tmo;
    error_cnt++;
    wrap_up();
  endtask
  task automatic chk(input string what, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %0h seen %0h", what, exp, seen);
    end
  endtask
  // Entered at a falling edge; n is the cycle in which done or fail shows
  task automatic acc(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, output int n);
    int w;
    w = 0;
    req = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    while (ready !== 1'b1) begin
      @(negedge sys_clk);
      w++;
      if (w > 100) tmo();
    end
    @(negedge sys_clk);
    req = 1'b0;
    n = 1;
    while (done !== 1'b1 && fail !== 1'b1) begin
      @(negedge sys_clk);
      n++;
      if (n > 100) tmo();
    end
  endtask
  initial begin
    {rstn, req, req_write, power_fail_level, junk} = '0;
    {alarm_irq_n, dev_rst_n, req_addr, req_wdata} = '1;
    repeat (8) @(negedge sys_clk);
    rstn = 1'b1;
    foreach (ta[i]) begin
      acc(1'b1, ta[i], td[i], n);
      chk("wr cycles", n, SETUP_CYC + PULSE_CYC + HOLD_CYC + 1);
      chk("window", clock_reg_access, ta[i] >= CLOCK_BASE_ADDR);
    end
    foreach (ta[i]) begin
      acc(1'b0, ta[i], 8'h00, n);
      chk("rd cycles", n, READ_CYC + SYNC_CYC + 1);
      chk("rd data", rd_data, td[i]);
    end
    fork
      acc(1'b1, ta[0], 8'h11, n);
      begin
        repeat (6) @(negedge sys_clk);
        power_fail_level = 1'b1;
      end
    join
    chk("fail", fail, 1'b1);
    @(negedge sys_clk);
    chk("blocked", {ready, ce_n, we_n, dq_oe}, 4'b0110);
    power_fail_level = 1'b0;
    acc(1'b0, ta[0], 8'h00, n);
    chk("kept", rd_data, td[0]);
    alarm_irq_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk("alarm", alarm_pending, 1'b1);
    alarm_irq_n = 1'b1;
    dev_rst_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk("held", {device_held, alarm_pending, ready}, 3'b100);
    dev_rst_n = 1'b1;
    acc(1'b0, ta[1], 8'h00, n);
    chk("after hold", rd_data, td[1]);
    // Seconds: load under write-halt, count, freeze under read-halt
    acc(1'b1, SECONDS_ADDR, 8'h58, n);
    acc(1'b1, CONTROL_ADDR, 8'h00, n);
    repeat (TICK_CYC * 3 / 2) @(negedge sys_clk);
    acc(1'b1, CONTROL_ADDR, 8'h40, n);
    acc(1'b0, SECONDS_ADDR, 8'h00, n);
    chk("sec loaded", rd_data, 8'h59);
    repeat (TICK_CYC) @(negedge sys_clk);
    acc(1'b0, SECONDS_ADDR, 8'h00, n);
    chk("sec frozen", rd_data, 8'h59);
    acc(1'b1, CONTROL_ADDR, 8'h00, n);
    repeat (TICK_CYC) @(negedge sys_clk);
    acc(1'b0, SECONDS_ADDR, 8'h00, n);
    chk("sec resumed", rd_data, 8'h01);
    acc(1'b1, CONTROL_ADDR, 8'h80, n);
    acc(1'b1, SECONDS_ADDR, 8'h80, n);
    acc(1'b1, CONTROL_ADDR, 8'h00, n);
    repeat (2 * TICK_CYC) @(negedge sys_clk);
    acc(1'b0, SECONDS_ADDR, 8'h00, n);
    chk("osc stopped", rd_data, 8'h80);
    // Second reset while idle: pins released, stored bytes kept
    rstn = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk("reset", {rd_data, device_held, ce_n, dq_oe}, 11'h006);
    rstn = 1'b1;
    acc(1'b0, ta[3], 8'h00, n);
    chk("after reset", rd_data, td[3]);
    wrap_up();
  end
endmodule // testbench
